/* design/path_control_consts.svh */
// Register indices, field positions, reset values and timing figures for the path control.
`ifndef PATH_CONTROL_CONSTS_SVH
`define PATH_CONTROL_CONSTS_SVH
// ==========================================================================
// Register indices (byte address is four times the index).
`define IDX_CONTROL 8'h00
`define IDX_CLK_CEIL 8'h10
`define IDX_VENDOR 8'h11
`define IDX_PRODUCT 8'h12
`define IDX_STATUS 8'h13
// ==========================================================================
// Control register fields.
`define CTL_WAKE_BIT 0
`define CTL_SEL_LO 1
`define CTL_SEL_HI 2
`define CTL_SW1_BIT 3
`define CTL_SW2_BIT 4
`define CTL_RESET 8'h18
// ==========================================================================
// Clock figures in MHz.
`define BASE_CLK_48 6'h30
`define BASE_CLK_52 6'h34
`define CARD_MAX_RESET 6'h19
`define CEIL_RESET 6'h00
// ==========================================================================
// Timing: poll interval in ms and clock rate in MHz.
`define POLL_MS 300
`define CLK_MHZ 250
// ==========================================================================
// Enumeration class code of a mass storage device.
`define USB_CLASS_MASS 8'h08
`endif

/* design/path_control_pkg.sv */
// Types shared by the path control block.
package path_control_pkg;
    // APB request carried as one bundle.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    // Card reader path selection codes.
    typedef enum logic [1:0] {
        READER_OFF = 2'b00,
        READER_PATH1 = 2'b01,
        READER_PATH2 = 2'b10,
        READER_OFF2 = 2'b11
    } reader_sel_e;
    // Reference clock choices.
    typedef enum logic [1:0] {
        REF_12 = 2'b00,
        REF_13 = 2'b01,
        REF_19P2 = 2'b10,
        REF_26 = 2'b11
    } ref_freq_e;
    // Presence polling states.
    typedef enum logic [1:0] {
        POLL_WAIT = 2'b00,
        POLL_PATH1 = 2'b01,
        POLL_PATH2 = 2'b10
    } poll_state_e;
endpackage

/* design/card_reader_path_control.sv */
// Path switch, card clock, presence polling and USB identity control with an APB slave.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "path_control_consts.svh"
module card_reader_path_control
    import path_control_pkg::*;
#(
    parameter int POLL_CYCLES = `POLL_MS * 1000 * `CLK_MHZ,
    parameter logic [15:0] VENDOR_DEFAULT = 16'h0001, // Arbitrary value.
    parameter logic [15:0] PRODUCT_DEFAULT = 16'h0002 // Arbitrary value.
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire apb_req_s apb_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire logic [1:0] ref_freq_in,
    input wire logic card_side_supply_in,
    input wire logic usb_hs_host_in,
    input wire logic card_max_valid_in,
    input wire logic [5:0] card_max_mhz_in,
    input wire logic poll_done_in,
    input wire logic poll_present_in,
    output logic path1_switch_close_out,
    output logic path2_switch_close_out,
    output logic controller_awake_out,
    output logic [1:0] reader_path_out,
    output logic [5:0] card_clk_mhz_out,
    output logic poll_req_out,
    output logic poll_path2_out,
    output logic usb_hs_mode_out,
    output logic [7:0] usb_class_out,
    output logic [15:0] usb_vendor_out,
    output logic [15:0] usb_product_out
);
    // ==========================================================================
    // Elaboration check: the poll counter must fit and be at least 2.
    initial
    begin
        if (POLL_CYCLES < 2 || POLL_CYCLES > 32'h7FFFFFFF)
        begin
            $error("POLL_CYCLES out of range");
        end
    end

    // ==========================================================================
    // Pin synchronisers. The first stage feeds only the second.
    logic supply_meta_reg;
    logic supply_sync_reg;
    logic hs_meta_reg;
    logic hs_sync_reg;
    always_ff @(posedge clk_in)
    begin
        supply_meta_reg <= rst_b_in ? card_side_supply_in : 1'b0;
        supply_sync_reg <= rst_b_in ? supply_meta_reg : 1'b0;
        hs_meta_reg <= rst_b_in ? usb_hs_host_in : 1'b0;
        hs_sync_reg <= rst_b_in ? hs_meta_reg : 1'b0;
    end

    // ==========================================================================
    // Register state.
    logic [7:0] control_reg; // Switches, reader select, wake.
    logic [5:0] ceil_reg; // Programmed clock ceiling, zero means none.
    logic [15:0] vendor_reg; // USB vendor identifier.
    logic [15:0] product_reg; // USB product identifier.
    logic [5:0] card_max_reg; // Maximum clock reported by the card.
    logic present1_reg; // Presence seen on path 1.
    logic present2_reg; // Presence seen on path 2.

    // ==========================================================================
    // APB decode. Registers are word aligned; other addresses answer an error.
    wire setup_phase = apb_in.psel && !apb_in.penable && !pready_out;
    wire access_done = apb_in.psel && apb_in.penable && pready_out;
    wire [7:0] reg_idx = apb_in.paddr[9:2];
    wire word_ok = (apb_in.paddr[1:0] == 2'b00) && (apb_in.paddr[11:10] == 2'b00);
    wire hit_control = word_ok && (reg_idx == `IDX_CONTROL);
    wire hit_ceil = word_ok && (reg_idx == `IDX_CLK_CEIL);
    wire hit_vendor = word_ok && (reg_idx == `IDX_VENDOR);
    wire hit_product = word_ok && (reg_idx == `IDX_PRODUCT);
    wire hit_status = word_ok && (reg_idx == `IDX_STATUS);
    wire hit_any = hit_control || hit_ceil || hit_vendor || hit_product || hit_status;
    wire wr_en = access_done && apb_in.pwrite && !pslverr_out;

    // ==========================================================================
    // Reader activity. Needs the controller awake and the card supply present.
    wire [1:0] sel_field = control_reg[`CTL_SEL_HI:`CTL_SEL_LO];
    wire running = control_reg[`CTL_WAKE_BIT] && supply_sync_reg;
    wire reader_p1 = running && (sel_field == READER_PATH1);
    wire reader_p2 = running && (sel_field == READER_PATH2);

    // Control write: the bit of a path held by the reader keeps its old value.
    wire [7:0] wdata8 = apb_in.pwdata[7:0];
    wire sw1_next = reader_p1 ? control_reg[`CTL_SW1_BIT] : wdata8[`CTL_SW1_BIT];
    wire sw2_next = reader_p2 ? control_reg[`CTL_SW2_BIT] : wdata8[`CTL_SW2_BIT];
    wire [7:0] control_next = {3'b000, sw2_next, sw1_next, wdata8[2:0]};

    // ==========================================================================
    // Card clock: least of base, card maximum and the programmed ceiling.
    wire [5:0] base_clk = (ref_freq_in == REF_13 || ref_freq_in == REF_26)
        ? `BASE_CLK_52 : `BASE_CLK_48;
    wire [5:0] card_lim = (card_max_reg < base_clk) ? card_max_reg : base_clk;
    wire ceil_on = (ceil_reg != 6'h00) && (ceil_reg < card_lim);
    wire [5:0] clk_next = ceil_on ? ceil_reg : card_lim;

    // ==========================================================================
    // Read mux.
    wire [31:0] status_word = {18'h00000, card_clk_mhz_out, 3'b000, controller_awake_out,
        (reader_p1 || reader_p2), usb_hs_mode_out, present2_reg, present1_reg};
    wire [31:0] rd_word = hit_control ? {24'h000000, control_reg} :
        hit_ceil ? {26'h0000000, ceil_reg} :
        hit_vendor ? {16'h0000, vendor_reg} :
        hit_product ? {16'h0000, product_reg} :
        hit_status ? status_word : 32'h00000000;

    // ==========================================================================
    // APB answer: no wait cycle, ready and error registered from the setup phase.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end
        else
        begin
            pready_out <= setup_phase;
            pslverr_out <= setup_phase && !hit_any;
            prdata_out <= setup_phase ? rd_word : prdata_out;
        end
    end

    // ==========================================================================
    // Register writes; status is read only. Writes work while asleep.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            control_reg <= `CTL_RESET;
            ceil_reg <= `CEIL_RESET;
            vendor_reg <= VENDOR_DEFAULT;
            product_reg <= PRODUCT_DEFAULT;
        end
        else if (wr_en)
        begin
            control_reg <= hit_control ? control_next : control_reg;
            ceil_reg <= hit_ceil ? apb_in.pwdata[5:0] : ceil_reg;
            vendor_reg <= hit_vendor ? apb_in.pwdata[15:0] : vendor_reg;
            product_reg <= hit_product ? apb_in.pwdata[15:0] : product_reg;
        end
    end

    // ==========================================================================
    // Card maximum is captured from the card engine, never from software.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            card_max_reg <= `CARD_MAX_RESET;
        end
        else if (card_max_valid_in && running)
        begin
            card_max_reg <= card_max_mhz_in;
        end
    end

    // ==========================================================================
    // Outputs. Switches open for the reader path and follow the bit otherwise.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            path1_switch_close_out <= 1'b1;
            path2_switch_close_out <= 1'b1;
            controller_awake_out <= 1'b0;
            reader_path_out <= READER_OFF;
            card_clk_mhz_out <= `CARD_MAX_RESET;
            usb_hs_mode_out <= 1'b0;
            usb_class_out <= `USB_CLASS_MASS;
            usb_vendor_out <= VENDOR_DEFAULT;
            usb_product_out <= PRODUCT_DEFAULT;
        end
        else
        begin
            path1_switch_close_out <= control_reg[`CTL_SW1_BIT] && !reader_p1;
            path2_switch_close_out <= control_reg[`CTL_SW2_BIT] && !reader_p2;
            controller_awake_out <= running;
            reader_path_out <= {reader_p2, reader_p1};
            card_clk_mhz_out <= clk_next;
            usb_hs_mode_out <= hs_sync_reg && running;
            usb_class_out <= `USB_CLASS_MASS;
            usb_vendor_out <= vendor_reg;
            usb_product_out <= product_reg;
        end
    end

    // ==========================================================================
    // Presence polling. No socket switch input exists; commands probe each path.
    // A card engine that never answers stalls polling; the engine must answer.
    poll_state_e poll_state_reg;
    logic [31:0] poll_cnt_reg; // Cycles to the next poll round.
    wire poll_tick = (poll_cnt_reg == 32'h00000000);
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || !running)
        begin
            poll_state_reg <= POLL_WAIT;
            poll_cnt_reg <= 32'(POLL_CYCLES - 1);
            poll_req_out <= 1'b0;
            poll_path2_out <= 1'b0;
            present1_reg <= present1_reg && rst_b_in;
            present2_reg <= present2_reg && rst_b_in;
        end
        else
        begin
            poll_req_out <= 1'b0;
            poll_cnt_reg <= poll_tick ? 32'(POLL_CYCLES - 1) : poll_cnt_reg - 32'h00000001;
            case (poll_state_reg)
                POLL_WAIT:
                begin
                    if (poll_tick)
                    begin
                        poll_state_reg <= POLL_PATH1;
                        poll_req_out <= 1'b1;
                        poll_path2_out <= 1'b0;
                    end
                end
                POLL_PATH1:
                begin
                    if (poll_done_in)
                    begin
                        present1_reg <= poll_present_in;
                        poll_state_reg <= POLL_PATH2;
                        poll_req_out <= 1'b1;
                        poll_path2_out <= 1'b1;
                    end
                end
                POLL_PATH2:
                begin
                    if (poll_done_in)
                    begin
                        present2_reg <= poll_present_in;
                        poll_state_reg <= POLL_WAIT;
                    end
                end
                default:
                begin
                    poll_state_reg <= POLL_WAIT;
                end
            endcase
        end
    end

    // ==========================================================================
    // Assertions and covers.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_CLK_LIMIT: assert property (##1 card_clk_mhz_out <= `BASE_CLK_52
        && card_clk_mhz_out <= $past(card_max_reg)) else $error("card clock above limit");
    AST_BASE_48: assert property ((ref_freq_in == REF_12 && card_max_reg > `BASE_CLK_52
        && ceil_reg == 6'h00) |=> card_clk_mhz_out == `BASE_CLK_48) else $error("base not 48");
    AST_CARD_MAX: assert property (!card_max_valid_in |=> $stable(card_max_reg))
        else $error("card maximum changed without card");
    AST_CEIL: assert property ((ceil_reg != 6'h00) |=> card_clk_mhz_out <= $past(ceil_reg))
        else $error("clock above ceiling");
    AST_SW1_FOLLOW: assert property (!reader_p1 |=> path1_switch_close_out ==
        $past(control_reg[`CTL_SW1_BIT])) else $error("switch 1 not following bit");
    AST_READER_OPEN: assert property (reader_p2 |=> !path2_switch_close_out)
        else $error("reader path switch closed");
    AST_WR_DISCARD: assert property ((reader_p1 && wr_en && hit_control) |=>
        $stable(control_reg[`CTL_SW1_BIT])) else $error("locked switch bit written");
    AST_WR_OTHER: assert property ((reader_p1 && wr_en && hit_control) |=>
        control_reg[`CTL_SW2_BIT] == $past(apb_in.pwdata[`CTL_SW2_BIT])) else $error("free bit lost");
    AST_IDLE: assert property (!supply_sync_reg |=> !poll_req_out
        && reader_path_out == 2'b00) else $error("activity without card supply");
    AST_ANSWER: assert property (setup_phase |=> pready_out ##1 !pready_out)
        else $error("APB answer timing");
    AST_CLASS: assert property (usb_class_out == `USB_CLASS_MASS)
        else $error("wrong class code");
    COV_READER1: cover property (reader_p1 ##2 !path1_switch_close_out);
    COV_POLL: cover property (poll_req_out ##[1:20] poll_done_in);
    COV_DISCARD: cover property (reader_p2 && wr_en && hit_control);
endmodule

/* sim/card_engine_model.sv */
// Behavioural card engine that answers presence probes for the path control.
`timescale 1ns/1ps
module card_engine_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic poll_req_in,
    input wire logic poll_path2_in,
    input wire logic present1_in,
    input wire logic present2_in,
    input wire logic [3:0] delay_in,
    output logic poll_done_out,
    output logic poll_present_out
);
    // ======================================================================
    // Probe answer logic.
    int wait_cnt; // Cycles left until the answer is given.
    logic path2_reg; // Path of the probe in flight.
    // Each probe is answered after a delay set by the bench, so both prompt and slow
    // cards are seen. Between answers the presence line means nothing, so it toggles.
    always @(posedge clk_in)
    begin
        poll_done_out <= 1'b0;
        poll_present_out <= ~poll_present_out;
        if (!rst_b_in)
        begin
            wait_cnt <= 0;
            poll_present_out <= 1'b0;
        end
        else if (poll_req_in)
        begin
            wait_cnt <= int'(delay_in) + 1;
            path2_reg <= poll_path2_in;
        end
        else if (wait_cnt == 1)
        begin
            wait_cnt <= 0;
            poll_done_out <= 1'b1;
            poll_present_out <= path2_reg ? present2_in : present1_in;
        end
        else if (wait_cnt > 1)
            wait_cnt <= wait_cnt - 1;
    end
endmodule

/* sim/card_reader_path_control_tb.sv */
// Self-checking bench for the card reader path control block.
`timescale 1ns/1ps
`include "path_control_consts.svh"
module card_reader_path_control_tb;
    import path_control_pkg::*;
    // ======================================================================
    // Stimulus, observed outputs and the reference model state.
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    apb_req_s apb = '0;
    logic [1:0] ref_freq = 2'h0;
    logic sup = 1'b1, hs = 1'b0, max_vld = 1'b0, pres1 = 1'b0, pres2 = 1'b0;
    logic [5:0] max_mhz = 6'h00;
    logic [3:0] dly = 4'h1;
    logic pdone, ppres, pready, pslverr, sw1, sw2, awake, preq, ppath2, hs_mode, er;
    logic [31:0] prdata, rd;
    logic [1:0] rdr;
    logic [5:0] cclk;
    logic [7:0] ucls;
    logic [15:0] uvid, upid;
    int n_fail = 0, checks_done = 0, seed = 58, m_ctl = 'h18, m_sup = 1, e, v, cl;
    logic [1:0] m_rdr = 2'h0; // Path the model believes the reader owns.
    localparam logic [11:0] A_CTL = {2'b00, `IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_CEIL = {2'b00, `IDX_CLK_CEIL, 2'b00};
    localparam logic [11:0] A_VID = {2'b00, `IDX_VENDOR, 2'b00};
    localparam logic [11:0] A_PID = {2'b00, `IDX_PRODUCT, 2'b00};
    localparam logic [11:0] A_ST = {2'b00, `IDX_STATUS, 2'b00};
    // A 4 ns clock; the short poll interval keeps the run brief.
    always #2 clk_in = ~clk_in;
    card_reader_path_control #(.POLL_CYCLES(50)) u_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .apb_in(apb), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .ref_freq_in(ref_freq),
        .card_side_supply_in(sup), .usb_hs_host_in(hs), .card_max_valid_in(max_vld),
        .card_max_mhz_in(max_mhz), .poll_done_in(pdone), .poll_present_in(ppres),
        .path1_switch_close_out(sw1), .path2_switch_close_out(sw2),
        .controller_awake_out(awake), .reader_path_out(rdr), .card_clk_mhz_out(cclk),
        .poll_req_out(preq), .poll_path2_out(ppath2), .usb_hs_mode_out(hs_mode),
        .usb_class_out(ucls), .usb_vendor_out(uvid), .usb_product_out(upid));
    card_engine_model u_card (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .poll_req_in(preq), .poll_path2_in(ppath2),
        .present1_in(pres1), .present2_in(pres2), .delay_in(dly),
        .poll_done_out(pdone), .poll_present_out(ppres));
    // ======================================================================
    // Verdict, comparison and bus tasks.
    task results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_pin(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks_done++;
        if (g !== ex)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_in);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        apb <= '0;
        if (k == 20)
        begin
            n_fail++;
            results();
        end
    endtask
    task automatic chk_reg(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb_xfer(1'b0, a, 32'h0);
        chk_pin(nm, ex, rd);
    endtask
    // Control write; a bit of the path that the reader owns keeps its old value.
    task automatic wr_ctl(input int wv);
        int nv;
        nv = wv & 'h1F;
        if (m_rdr[0])
            nv = (nv & 'h17) | (m_ctl & 'h08);
        if (m_rdr[1])
            nv = (nv & 'h0F) | (m_ctl & 'h10);
        apb_xfer(1'b1, A_CTL, 32'(wv));
        m_ctl = nv;
    endtask
    // Works out reader and switch states from the model and compares them.
    task automatic chk_state();
        int s;
        s = (m_ctl >> 1) & 3;
        m_rdr = ((m_ctl & 1) != 0 && m_sup != 0) ? {s == 2, s == 1} : 2'b00;
        repeat (4) @(posedge clk_in);
        chk_pin("reader", 32'(m_rdr), 32'(rdr));
        chk_pin("sw1", ((m_ctl >> 3) & 1) & ~m_rdr[0], 32'(sw1));
        chk_pin("sw2", ((m_ctl >> 4) & 1) & ~m_rdr[1], 32'(sw2));
        chk_pin("awake", m_ctl & m_sup & 1, 32'(awake));
        chk_reg("control", A_CTL, m_ctl);
    endtask
    // Waits for a probe; a loose wait lines up on a probe of the path given by p first.
    task automatic wait_req(input logic p, input logic strict);
        int k;
        for (k = 0; k < 300; k++)
        begin
            @(posedge clk_in);
            if (preq === 1'b1 && (strict || ppath2 === p))
                break;
        end
        chk_pin("probe path", 32'(p), 32'(ppath2));
        if (k == 300)
        begin
            n_fail++;
            results();
        end
    endtask
    // ======================================================================
    // Main sequence.
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        chk_state();
        chk_pin("class", `USB_CLASS_MASS, 32'(ucls));
        chk_pin("card clock", `CARD_MAX_RESET, 32'(cclk));
        chk_reg("ceiling", A_CEIL, 32'h0);
        chk_reg("vendor", A_VID, 32'h0001);
        chk_reg("product", A_PID, 32'h0002);
        chk_reg("unmapped", 12'h100, 32'h0);
        chk_pin("slverr", 32'h1, 32'(er));
        // Asleep first, then every select code awake with random switch bits.
        for (int i = 0; i < 16; i++)
        begin
            wr_ctl(($random(seed) & 'hF8) | ((i % 4) << 1) | (i >= 4 ? 1 : 0));
            chk_state();
        end
        // Idle supply: registers take writes, yet nothing runs.
        sup <= 1'b0;
        m_sup = 0;
        chk_state();
        wr_ctl('h1B);
        chk_state();
        sup <= 1'b1;
        m_sup = 1;
        chk_state();
        wr_ctl('h03);
        chk_state();
        wr_ctl('h19);
        chk_state();
        // Tied host ports: the host closes one path switch at a time.
        wr_ctl('h09);
        chk_state();
        wr_ctl('h11);
        chk_state();
        // Card clock for each reference, card maximum and ceiling.
        for (int r = 0; r < 4; r++)
        begin
            // The 12 MHz case uses a fast card and no ceiling, so the base alone limits.
            v = (r == 0) ? 'h3F : ($random(seed) & 'h3F);
            cl = (r < 2) ? 0 : ($random(seed) & 'h3F);
            ref_freq <= 2'(r);
            max_mhz <= 6'(v);
            apb_xfer(1'b1, A_CEIL, 32'(cl));
            @(posedge clk_in);
            max_vld <= 1'b1;
            @(posedge clk_in);
            max_vld <= 1'b0;
            e = (r % 2 == 1) ? 52 : 48;
            e = (v < e) ? v : e;
            e = (cl != 0 && cl < e) ? cl : e;
            repeat (3) @(posedge clk_in);
            chk_pin("card clock", e, 32'(cclk));
            chk_reg("ceiling", A_CEIL, cl);
            apb_xfer(1'b0, A_ST, 32'h0);
            chk_pin("status clock", e, (rd >> 8) & 'h3F);
            chk_pin("status flags", 32'h10, rd & 'h1C);
        end
        // Link speed follows the host.
        for (int h = 1; h >= 0; h--)
        begin
            hs <= 1'(h);
            repeat (6) @(posedge clk_in);
            chk_pin("hs mode", h, 32'(hs_mode));
        end
        // Identifiers are replaced through the bus and reach the USB side.
        for (int k = 0; k < 2; k++)
        begin
            v = $random(seed) & 'hFFFF;
            apb_xfer(1'b1, k ? A_PID : A_VID, 32'(v));
            chk_reg("ident", k ? A_PID : A_VID, v);
            chk_pin("ident out", v, k ? 32'(upid) : 32'(uvid));
        end
        // Presence polling with a prompt and then a slow card engine.
        for (int p = 0; p < 2; p++)
        begin
            pres1 <= 1'(p == 0);
            pres2 <= 1'(p == 1);
            dly <= p ? 4'h9 : 4'h1;
            wait_req(1'b0, 1'b0);
            wait_req(1'b1, 1'b1);
            wait_req(1'b0, 1'b1);
            wait_req(1'b1, 1'b1);
            repeat (20) @(posedge clk_in);
            apb_xfer(1'b0, A_ST, 32'h0);
            chk_pin("presence", p ? 2 : 1, rd & 3);
        end
        results();
    end
endmodule
